//--- rtl/dar_arm_request.sv
// What this block does
// [RULE1] Five channels 0 to 4 each own the arm bit at their own index.
// [RULE2] A channel does nothing at all while its arm bit is zero.
// [RULE3] Completion in a non-repeating mode clears the arm bit; repeating modes keep it.
// [RULE4] Writing one to arm bit 7 aborts every channel whose arm bit is one in that write.
// [RULE5] The abort bit reads zero and writing zero to it changes nothing.
// [RULE6] Arm bits 6 and 5 are plain storage that resets to zero and steers nothing.
// [RULE7] Writing one to a request bit starts that channel like one trigger.
// [RULE8] A started channel stops on completion or when its arm bit is cleared, not by a zero request write.
// [RULE9] A request bit clears on grant to its channel and ignores software zeros.
// [RULE10] Request bits 7 to 5 read as zero.
// [RULE11] Arm, abort and request bits all reset to zero.
// [RULE12] Mode 00 single, 01 block, 10 repeated single, 11 repeated block; 00 and 01 do not repeat.
// [RULE13] Trigger select 00000 means only a software request can start the channel.
// [RULE14] A completed transfer sets that channel's done flag.
// [RULE15] An aborted channel is disarmed, loses pending starts and gets no done flag.
// [RULE16] An abort lets any bus access in flight finish before taking effect.
`timescale 1ns/1ps
module dar_arm_request #(
	parameter int NUM_CH = dar_pkg::NUM_CH
) (
	input  wire logic                              clk,
	input  wire logic                              resetn,
	input  wire logic [dar_pkg::ADDR_W-1:0]        sfrAddr,
	input  wire logic                              sfrWrite,
	input  wire logic                              sfrRead,
	input  wire logic [dar_pkg::REG_W-1:0]         sfrWdata,
	output logic      [dar_pkg::REG_W-1:0]         sfrRdata,
	input  wire logic [NUM_CH*dar_pkg::TRIGGER_SELECT_W-1:0] trigSel,
	input  wire logic [NUM_CH*dar_pkg::MODE_W-1:0] xferMode,
	input  wire logic [NUM_CH-1:0]                 hwTrig,
	input  wire logic [NUM_CH-1:0]                 chGrant,
	input  wire logic [NUM_CH-1:0]                 xferDone,
	input  wire logic                              busAccessBusy,
	input  wire logic [NUM_CH-1:0]                 doneFlagClear,
	output logic      [NUM_CH-1:0]                 chBusReq,
	output logic      [NUM_CH-1:0]                 chAbort,
	output logic      [NUM_CH-1:0]                 doneFlag
);
	import dar_pkg::*;

	localparam int UNUSED_W = ARM_UNUSED_HI - ARM_UNUSED_LO + 1;

	logic [NUM_CH-1:0]   armBits;
	logic [NUM_CH-1:0]   next_armBits;
	logic [UNUSED_W-1:0] armUnused;
	logic [NUM_CH-1:0]   softReq;
	logic [NUM_CH-1:0]   next_softReq;
	logic [NUM_CH-1:0]   abortSel;
	logic [NUM_CH-1:0]   next_abortSel;
	logic [NUM_CH-1:0]   next_doneFlag;
	logic [REG_W-1:0]    next_rdata;
	dar_abort_state_t    abortState;
	dar_abort_state_t    next_abortState;

	// Register decode
	wire armSel      = (sfrAddr == ADDR_ARM);
	wire reqSel      = (sfrAddr == ADDR_SOFT_REQ);
	wire armWrite    = sfrWrite & armSel;
	wire reqWrite    = sfrWrite & reqSel;
	wire abortWrite  = armWrite & sfrWdata[ABORT_BIT];                   // RULE4 RULE5
	wire plainArmWr  = armWrite & ~sfrWdata[ABORT_BIT];                  // RULE5
	wire [NUM_CH-1:0] wrChan = sfrWdata[NUM_CH-1:0];                     // RULE1

	// Per-channel engine status
	wire [NUM_CH-1:0] busReqRaw;
	wire [NUM_CH-1:0] chActive;
	wire [NUM_CH-1:0] complete;
	wire [NUM_CH-1:0] disarm;
	wire [NUM_CH-1:0] nonRepeat;

	// Abort is held back until the bus is free of a partial access
	wire              draining = (abortState == AB_DRAIN);
	wire              abortGo  = draining & ~busAccessBusy;                // RULE16
	wire [NUM_CH-1:0] abortNow = abortGo ? abortSel : '0;                 // RULE4

	// Channels being aborted may not win the bus again
	assign chBusReq = busReqRaw & ~(draining ? abortSel : '0);           // RULE16
	assign chAbort  = abortNow;
	wire [NUM_CH-1:0] grantEff = chGrant & armBits;                      // RULE2

	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
			assign nonRepeat[ch] = ~xferMode[ch*MODE_W+MODE_REPEAT_BIT]; // RULE12
			dar_channel u_chan (
				.clk      (clk),
				.resetn   (resetn),
				.armed    (armBits[ch]),
				.softReq  (softReq[ch]),
				.hwTrig   (hwTrig[ch]),
				.trigSel  (trigSel[ch*TRIGGER_SELECT_W +: TRIGGER_SELECT_W]),
				.mode     (xferMode[ch*MODE_W +: MODE_W]),
				.grant    (grantEff[ch]),
				.xferDone (xferDone[ch]),
				.abort    (abortNow[ch]),
				.busReq   (busReqRaw[ch]),
				.active   (chActive[ch]),
				.complete (complete[ch]),
				.disarm   (disarm[ch])
			);
		end
	endgenerate

	// Software arm write wins over a hardware disarm in the same cycle
	assign next_armBits = plainArmWr ? wrChan
	                                 : (armBits & ~abortNow & ~disarm);  // RULE3 RULE8 RULE15

	// Set wins over grant; zeros written are ignored
	assign next_softReq = (softReq & ~grantEff & ~abortNow)
	                    | (reqWrite ? wrChan : '0);                     // RULE7 RULE9 RULE15

	assign next_abortSel = abortGo ? (abortWrite ? wrChan : '0)
	                               : (abortSel | (abortWrite ? wrChan : '0)); // RULE4

	assign next_abortState = (next_abortSel != '0) ? AB_DRAIN : AB_IDLE;

	assign next_doneFlag = (doneFlag & ~doneFlagClear) | complete;      // RULE14

	// Readback; abort bit and upper request bits read zero
	assign next_rdata = !sfrRead ? RDATA_RESET
	                  : armSel   ? {1'b0, armUnused, armBits}            // RULE5
	                  : reqSel   ? {{REQ_UNUSED_W{1'b0}}, softReq}       // RULE10
	                  : RDATA_RESET;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			armBits    <= ARM_RESET[NUM_CH-1:0];                         // RULE11
			armUnused  <= ARM_RESET[ARM_UNUSED_HI:ARM_UNUSED_LO];        // RULE11
			softReq    <= REQ_RESET[NUM_CH-1:0];                         // RULE11
			abortSel   <= '0;
			abortState <= AB_IDLE;
			doneFlag   <= '0;
			sfrRdata   <= RDATA_RESET;
		end else begin
			armBits    <= next_armBits;
			softReq    <= next_softReq;
			abortSel   <= next_abortSel;
			abortState <= next_abortState;
			doneFlag   <= next_doneFlag;
			sfrRdata   <= next_rdata;
			if (armWrite) begin
				armUnused <= sfrWdata[ARM_UNUSED_HI:ARM_UNUSED_LO];      // RULE6
			end
		end
	end

	// Checks
	a_unarmed_idle: assert property (@(posedge clk) disable iff (!resetn) // RULE2
		(busReqRaw & ~armBits) == '0 && (chActive & ~$past(armBits)) == '0)
		else $error("unarmed channel requested or ran");

	a_single_disarm: assert property (@(posedge clk) disable iff (!resetn) // RULE3
		((complete & nonRepeat) != '0) && !plainArmWr
		|=> (armBits & $past(complete & nonRepeat)) == '0)
		else $error("non-repeating channel stayed armed");

	a_repeat_keeps: assert property (@(posedge clk) disable iff (!resetn) // RULE3
		((complete & ~nonRepeat) != '0) && !armWrite && abortSel == '0
		|=> (armBits & $past(complete & ~nonRepeat)) == $past(complete & ~nonRepeat))
		else $error("repeating channel lost arm");

	a_abort_clears: assert property (@(posedge clk) disable iff (!resetn) // RULE4
		abortWrite && !busAccessBusy && abortSel == '0 && wrChan != '0 ##1 !busAccessBusy && !plainArmWr
		|=> (armBits & $past(wrChan, 2)) == '0)
		else $error("abort did not disarm selected channels");

	a_abort_readzero: assert property (@(posedge clk) disable iff (!resetn) // RULE5
		sfrRead && armSel |=> !sfrRdata[ABORT_BIT] && sfrRdata[NUM_CH-1:0] == $past(armBits))
		else $error("arm readback wrong");

	a_unused_store: assert property (@(posedge clk) disable iff (!resetn) // RULE6
		armWrite |=> armUnused == $past(sfrWdata[ARM_UNUSED_HI:ARM_UNUSED_LO]))
		else $error("unused arm bits not stored");

	a_req_sets: assert property (@(posedge clk) disable iff (!resetn) // RULE7
		reqWrite |=> (softReq & $past(wrChan & ~abortNow)) == $past(wrChan & ~abortNow))
		else $error("request bit not set by write");

	a_zero_ignored: assert property (@(posedge clk) disable iff (!resetn) // RULE9
		reqWrite && grantEff == '0 && abortNow == '0 |=> (softReq & $past(softReq)) == $past(softReq))
		else $error("zero write cleared request");

	a_grant_clears: assert property (@(posedge clk) disable iff (!resetn) // RULE9
		grantEff != '0 && !reqWrite |=> (softReq & $past(grantEff)) == '0)
		else $error("grant did not clear request");

	a_req_upper_zero: assert property (@(posedge clk) disable iff (!resetn) // RULE10
		sfrRead && reqSel |=> sfrRdata[REG_W-1:NUM_CH] == '0)
		else $error("request upper bits not zero");

	a_done_sets: assert property (@(posedge clk) disable iff (!resetn) // RULE14
		complete != '0 |=> (doneFlag & $past(complete)) == $past(complete))
		else $error("done flag not set");

	a_abort_nodone: assert property (@(posedge clk) disable iff (!resetn) // RULE15
		abortNow != '0 |-> (complete & abortNow) == '0 ##1 (chActive & $past(abortNow)) == '0)
		else $error("aborted channel completed or kept running");

	a_drain_waits: assert property (@(posedge clk) disable iff (!resetn) // RULE16
		draining && busAccessBusy |-> abortNow == '0 && (chBusReq & abortSel) == '0)
		else $error("abort cut an access in flight");
endmodule // dar_arm_request

//--- rtl/dar_pkg.sv
package dar_pkg;
	localparam int          NUM_CH          = 5;
	localparam int          TRIGGER_SELECT_W          = 5;
	localparam int          MODE_W          = 2;
	localparam int          REG_W           = 8;
	localparam int          ADDR_W          = 8;

	localparam logic [7:0]  ADDR_ARM        = 8'hD6;
	localparam logic [7:0]  ADDR_SOFT_REQ   = 8'hD7;

	localparam int          ABORT_BIT       = 7;
	localparam int          ARM_UNUSED_LO   = 5;
	localparam int          ARM_UNUSED_HI   = 6;
	localparam int          REQ_UNUSED_W    = 3;

	localparam logic [7:0]  ARM_RESET       = 8'h00;
	localparam logic [7:0]  REQ_RESET       = 8'h00;
	localparam logic [7:0]  RDATA_RESET     = 8'h00;

	localparam logic [1:0]  MODE_SINGLE     = 2'h0;
	localparam logic [1:0]  MODE_BLOCK      = 2'h1;
	localparam logic [1:0]  MODE_REP_SINGLE = 2'h2;
	localparam logic [1:0]  MODE_REP_BLOCK  = 2'h3;
	localparam int          MODE_REPEAT_BIT = 1;

	localparam logic [4:0]  TRIGGER_SELECT_NONE       = 5'h00;

	typedef enum logic [1:0] {
		AB_IDLE  = 2'b01,
		AB_DRAIN = 2'b10
	} dar_abort_state_t;
endpackage

//--- rtl/dar_channel.sv
`timescale 1ns/1ps
module dar_channel (
	input  wire logic                       clk,
	input  wire logic                       resetn,
	input  wire logic                       armed,
	input  wire logic                       softReq,
	input  wire logic                       hwTrig,
	input  wire logic [dar_pkg::TRIGGER_SELECT_W-1:0] trigSel,
	input  wire logic [dar_pkg::MODE_W-1:0] mode,
	input  wire logic                       grant,
	input  wire logic                       xferDone,
	input  wire logic                       abort,
	output logic                            busReq,
	output logic                            active,
	output logic                            complete,
	output logic                            disarm
);
	import dar_pkg::*;

	logic pending;
	logic next_pending;
	logic next_active;
	wire  hwFire = hwTrig & (trigSel != TRIGGER_SELECT_NONE);                     // RULE13

	// A trigger seen while a grant retires the old one is kept
	assign next_pending = armed & ~abort & ((pending & ~grant) | hwFire); // RULE2 RULE15
	// Only completion, disarm or abort ends a started channel
	assign next_active  = armed & ~abort & ~xferDone & (active | grant); // RULE8 RULE15

	assign busReq   = armed & ~abort & (pending | softReq | active);     // RULE2 RULE7
	assign complete = active & xferDone & armed & ~abort;               // RULE14 RULE15
	assign disarm   = complete & ~mode[MODE_REPEAT_BIT];                // RULE3 RULE12

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pending <= 1'b0;
			active  <= 1'b0;
		end else begin
			pending <= next_pending;
			active  <= next_active;
		end
	end
endmodule // dar_channel

//--- test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import dar_pkg::*;
	logic        clk           = 1'b0;
	logic        resetn        = 1'b0;
	logic [7:0]  sfrAddr       = 8'h00;
	logic        sfrWrite      = 1'b0;
	logic        sfrRead       = 1'b0;
	logic [7:0]  sfrWdata      = 8'h00;
	logic [7:0]  sfrRdata;
	logic [24:0] trigSel       = '0;
	logic [9:0]  xferMode      = '0;
	logic [4:0]  hwTrig        = 5'h00;
	logic [4:0]  chGrant       = 5'h00;
	logic [4:0]  xferDone      = 5'h00;
	logic        busAccessBusy = 1'b0;
	logic [4:0]  doneFlagClear = 5'h00;
	logic [4:0]  chBusReq;
	logic [4:0]  chAbort;
	logic [4:0]  doneFlag;
	logic [7:0]  rdv;
	logic [2:0]  m;
	int          failCount     = 0;
	int          checked       = 0;
	// Address, write data, expected read back
	logic [23:0] rows [6]      = '{24'hD6_6060, 24'hD6_1F1F, 24'hD6_0000, 24'hD7_E000, 24'hD5_FF00, 24'hD7_0000};
	always #50 clk = ~clk;
	dar_arm_request DUT (.clk(clk), .resetn(resetn), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrRead(sfrRead),
		.sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .trigSel(trigSel), .xferMode(xferMode), .hwTrig(hwTrig),
		.chGrant(chGrant), .xferDone(xferDone), .busAccessBusy(busAccessBusy), .doneFlagClear(doneFlagClear),
		.chBusReq(chBusReq), .chAbort(chAbort), .doneFlag(doneFlag));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			failCount++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks=%0d mismatches=%0d", checked, failCount);
		if (failCount == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Each register cycle lets one idle cycle pass first, so a strobe never toggles twice in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfrAddr = a;
		sfrWdata = d;
		sfrWrite = 1'b1;
		@(negedge clk);
		sfrWrite = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		sfrAddr = a;
		sfrRead = 1'b1;
		@(negedge clk);
		sfrRead = 1'b0;
		d = sfrRdata;
	endtask
	initial begin
		repeat (12) @(negedge clk);
		resetn = 1'b1;
		chk({3'h0, chBusReq | chAbort | doneFlag}, 8'h00);
		rd(ADDR_ARM, rdv);
		chk(rdv, 8'h00);
		rd(ADDR_SOFT_REQ, rdv);
		chk(rdv, 8'h00);
		for (int i = 0; i < 6; i++) begin
			wr(rows[i][23:16], rows[i][15:8]);
			rd(rows[i][23:16], rdv);
			chk(rdv, rows[i][7:0]);
		end
		// Request while unarmed stays pending and idle
		wr(ADDR_SOFT_REQ, 8'h01);
		chk({3'h0, chBusReq}, 8'h00);
		for (m = 0; m < 4; m++) begin
			xferMode = {5{m[1:0]}};
			wr(ADDR_ARM, 8'h01);
			wr(ADDR_SOFT_REQ, 8'h01);
			wr(ADDR_SOFT_REQ, 8'h00);
			chk({7'h0, chBusReq[0]}, 8'h01);
			chGrant = 5'h01;
			@(negedge clk);
			chGrant = 5'h00;
			rd(ADDR_SOFT_REQ, rdv);
			chk(rdv, 8'h00);
			xferDone = 5'h01;
			@(negedge clk);
			xferDone = 5'h00;
			chk({3'h0, doneFlag}, 8'h01);
			rd(ADDR_ARM, rdv);
			chk(rdv, {7'h0, m[1]});
			doneFlagClear = 5'h01;
			@(negedge clk);
			doneFlagClear = 5'h00;
		end
		chk({3'h0, doneFlag}, 8'h00);
		// Hardware trigger on channel 2, ignored with no trigger selected
		wr(ADDR_ARM, 8'h04);
		hwTrig = 5'h04;
		@(negedge clk);
		hwTrig = 5'h00;
		chk({3'h0, chBusReq}, 8'h00);
		trigSel[14:10] = 5'h03;
		hwTrig = 5'h04;
		@(negedge clk);
		hwTrig = 5'h00;
		chk({3'h0, chBusReq}, 8'h04);
		wr(ADDR_ARM, 8'h00);
		chk({3'h0, chBusReq}, 8'h00);
		// Abort channel 0 while a bus access is in flight
		wr(ADDR_ARM, 8'h03);
		wr(ADDR_SOFT_REQ, 8'h03);
		busAccessBusy = 1'b1;
		wr(ADDR_ARM, 8'h81);
		@(negedge clk);
		chk({3'h0, chAbort}, 8'h00);
		chk({3'h0, chBusReq}, 8'h02);
		busAccessBusy = 1'b0;
		for (int i = 0; i <= 4; i++) begin
			#1;
			if (chAbort !== 5'h00)
				break;
			if (i == 4) begin
				failCount++;
				complete_run();
			end
			@(negedge clk);
		end
		chk({3'h0, chAbort}, 8'h01);
		repeat (2) @(negedge clk);
		rd(ADDR_ARM, rdv);
		chk(rdv, 8'h02);
		rd(ADDR_SOFT_REQ, rdv);
		chk(rdv, 8'h02);
		chk({3'h0, chBusReq | doneFlag}, 8'h02);
		// Abort a running channel with the bus idle; a completion in the abort cycle is dropped
		chGrant = 5'h02;
		@(negedge clk);
		chGrant = 5'h00;
		wr(ADDR_ARM, 8'h82);
		chk({3'h0, chAbort}, 8'h02);
		xferDone = 5'h02;
		@(negedge clk);
		xferDone = 5'h00;
		chk({3'h0, chBusReq | chAbort | doneFlag}, 8'h00);
		rd(ADDR_ARM, rdv);
		chk(rdv, 8'h00);
		// Reset in mid-run clears every stored bit
		wr(ADDR_ARM, 8'h7F);
		wr(ADDR_SOFT_REQ, 8'h1F);
		chk({3'h0, chBusReq}, 8'h1F);
		resetn = 1'b0;
		@(negedge clk);
		resetn = 1'b1;
		chk({3'h0, chBusReq | chAbort | doneFlag}, 8'h00);
		rd(ADDR_ARM, rdv);
		chk(rdv, 8'h00);
		rd(ADDR_SOFT_REQ, rdv);
		chk(rdv, 8'h00);
		complete_run();
	end
endmodule // tb_top
